// File: hw/hbc_pkg.sv
// Constants shared by the hub boot and configuration sequencer
package hbc_pkg;

    // Sequencer stages
    typedef enum logic [3:0] {
        ST_STANDBY  = 4'h0,
        ST_HARDWARE_INIT_STAGE  = 4'h1,
        ST_FW_INIT  = 4'h2,
        ST_HOST_CFG = 4'h3,
        ST_MERGE    = 4'h4,
        ST_APPLY    = 4'h5,
        ST_IDLE     = 4'h6,
        ST_CHG_DET  = 4'h7,
        ST_ATTACH   = 4'h8,
        ST_NORMAL   = 4'h9
    } hbc_stage_e;

    // Configuration source chosen in firmware init
    typedef enum logic [2:0] {
        SRC_SELF_PWR = 3'h0,
        SRC_BUS_PWR  = 3'h1,
        SRC_EEPROM   = 3'h2,
        SRC_HOST     = 3'h3,
        SRC_INVALID  = 3'h4
    } hbc_source_e;

    // Strap encodings of the configuration-method pair
    localparam logic [1:0] SEL_SELF_PWR = 2'h0;
    localparam logic [1:0] SEL_HOST     = 2'h1;
    localparam logic [1:0] SEL_BUS_PWR  = 2'h2;
    localparam logic [1:0] SEL_EEPROM   = 2'h3;

    // SMBus register map
    localparam logic [7:0] ADDR_CFG_DONE  = 8'hFF;
    localparam logic [7:0] ADDR_PORTABLE  = 8'hF4;
    localparam logic [7:0] ADDR_UPS_CHG   = 8'hF5;
    localparam int         BIT_KEEP_AWAKE = 0;
    localparam int         BIT_UPS_CHG_EN = 0;

    // Reset values
    localparam logic RST_KEEP_AWAKE = 1'b0;
    localparam logic RST_CHG_EN     = 1'b0;
    localparam logic RST_VSM_EC     = 1'b0;
    localparam logic RST_VSM_RESUME = 1'b0;

    // Vendor message command codes
    localparam logic [2:0] VSM_EC_ON      = 3'h1;
    localparam logic [2:0] VSM_EC_OFF     = 3'h2;
    localparam logic [2:0] VSM_RESUME_ON  = 3'h3;
    localparam logic [2:0] VSM_RESUME_OFF = 3'h4;
    localparam logic [2:0] VSM_HUB_RESET  = 3'h5;

    // Timing
    localparam int CLK_PERIOD_NS    = 10;
    localparam int HARDWARE_INIT_STAGE_NS       = 100;
    localparam int PD_SETTLE_NS     = 2000;
    localparam int HARDWARE_INIT_STAGE_CYCLES   =
        (HARDWARE_INIT_STAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PD_SETTLE_CYCLES =
        (PD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W            = 8;

endpackage

// File: hw/hbc_sync2.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module hbc_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // hbc_sync2

// File: hw/hbc_boot_seq.sv
// Hub boot and configuration sequencer
`timescale 1ns/1ps
module hbc_boot_seq (
    input  wire logic       REF_CLK,
    input  wire logic       RESETN,
    input  wire logic       REF_CLK_OK,
    input  wire logic [1:0] STRAP_CFG_SEL,
    input  wire logic       SDA_IN,
    input  wire logic       SCL_IN,
    input  wire logic       VBUS_PRESENT,
    input  wire logic       HUB_ATTACH_REQ,
    input  wire logic       SOFT_DISCONNECT,
    input  wire logic       USB_SUSPEND,
    input  wire logic       OTP_UPS_CHG_EN,
    input  wire logic       SMB_WR_VALID,
    input  wire logic [7:0] SMB_WR_ADDR,
    input  wire logic [7:0] SMB_WR_DATA,
    input  wire logic       EEPROM_LOAD_DONE,
    input  wire logic       EEPROM_UPS_CHG_EN,
    input  wire logic       CHG_DET_DONE,
    input  wire logic       VSM_CMD_VALID,
    input  wire logic [2:0] VSM_CMD,
    output logic            SDA_PD_EN,
    output logic            SCL_PD_EN,
    output logic            SMB_ENABLE,
    output logic            CLK_STOP_REQ,
    output logic [3:0]      STAGE,
    output logic [2:0]      CFG_SOURCE,
    output logic            EEPROM_LOAD_REQ,
    output logic            CFG_APPLY,
    output logic            UPS_CHG_EN,
    output logic            CHG_DET_START,
    output logic            HUB_CONNECT,
    output logic            SUSPEND_IDLE,
    output logic            VSM_EC_ENABLE,
    output logic            VSM_RESUME_ENABLE,
    output logic            VSM_HUB_RESET
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [7:0] pins_raw;
    logic [7:0] pins_s;
    logic       clk_ok_s;
    logic [1:0] sel_s;
    logic       sda_s;
    logic       scl_s;
    logic       vbus_s;
    logic       attach_s;
    logic       soft_disc_s;

    assign pins_raw = {REF_CLK_OK, STRAP_CFG_SEL, SDA_IN, SCL_IN,
                       VBUS_PRESENT, HUB_ATTACH_REQ, SOFT_DISCONNECT};

    hbc_sync2 #(.WIDTH(8)) u_sync (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .d     (pins_raw),
        .q     (pins_s)
    );

    assign {clk_ok_s, sel_s, sda_s, scl_s, vbus_s, attach_s,
            soft_disc_s} = pins_s;

    ////////////////////////////////////////////////////////////////////////
    // Stage machine

    hbc_pkg::hbc_stage_e  stage;
    hbc_pkg::hbc_stage_e  next_stage;
    hbc_pkg::hbc_source_e source;
    hbc_pkg::hbc_source_e next_source;
    logic [1:0]           strap;
    logic [hbc_pkg::CNT_W-1:0] cnt;
    logic                 cnt_done;
    logic                 host_done;
    logic                 host_chg_set;
    logic                 host_chg_val;
    logic                 keep_awake;
    logic                 awake_latched;
    logic                 susp_d;
    logic                 cfg_wr;

    assign cfg_wr = SMB_ENABLE && SMB_WR_VALID;

    // Source decode of straps and SDA and SCL levels
    function automatic hbc_pkg::hbc_source_e pick_source(
        input logic [1:0] sel,
        input logic       sda,
        input logic       scl
    );
        hbc_pkg::hbc_source_e res;
        res = hbc_pkg::SRC_INVALID;
        case (sel)
            hbc_pkg::SEL_EEPROM:   res = hbc_pkg::SRC_EEPROM;
            hbc_pkg::SEL_HOST:
                res = sda ? hbc_pkg::SRC_HOST : hbc_pkg::SRC_INVALID;
            hbc_pkg::SEL_BUS_PWR:
                res = (sda && scl) ? hbc_pkg::SRC_HOST
                                   : hbc_pkg::SRC_BUS_PWR;
            default:
                res = (sda && scl) ? hbc_pkg::SRC_HOST
                                   : hbc_pkg::SRC_SELF_PWR;
        endcase
        return res;
    endfunction

    assign cnt_done = (stage == hbc_pkg::ST_HARDWARE_INIT_STAGE) ?
        (cnt >= hbc_pkg::CNT_W'(hbc_pkg::HARDWARE_INIT_STAGE_CYCLES)) :
        (cnt >= hbc_pkg::CNT_W'(hbc_pkg::PD_SETTLE_CYCLES));

    always_comb begin
        next_stage  = stage;
        next_source = source;
        case (stage)
            hbc_pkg::ST_STANDBY:
                next_stage = hbc_pkg::ST_HARDWARE_INIT_STAGE;
            hbc_pkg::ST_HARDWARE_INIT_STAGE:
                if (cnt_done && clk_ok_s) begin
                    next_stage = hbc_pkg::ST_FW_INIT;
                end
            hbc_pkg::ST_FW_INIT: begin
                // EEPROM straps skip the bus probe and its settle time
                if (strap == hbc_pkg::SEL_EEPROM) begin
                    next_source = hbc_pkg::SRC_EEPROM;
                    next_stage  = hbc_pkg::ST_MERGE;
                end else if (cnt_done) begin
                    next_source = pick_source(strap, sda_s, scl_s);
                    if (next_source == hbc_pkg::SRC_HOST) begin
                        next_stage = hbc_pkg::ST_HOST_CFG;
                    end else if (next_source != hbc_pkg::SRC_INVALID) begin
                        next_stage = hbc_pkg::ST_MERGE;
                    end
                end
            end
            hbc_pkg::ST_HOST_CFG:
                if (host_done) begin
                    next_stage = hbc_pkg::ST_MERGE;
                end
            hbc_pkg::ST_MERGE:
                if (source != hbc_pkg::SRC_EEPROM || EEPROM_LOAD_DONE) begin
                    next_stage = hbc_pkg::ST_APPLY;
                end
            hbc_pkg::ST_APPLY:
                next_stage = hbc_pkg::ST_IDLE;
            hbc_pkg::ST_IDLE:
                if (vbus_s || attach_s) begin
                    next_stage = UPS_CHG_EN ? hbc_pkg::ST_CHG_DET
                                            : hbc_pkg::ST_ATTACH;
                end
            hbc_pkg::ST_CHG_DET:
                if (CHG_DET_DONE) begin
                    next_stage = hbc_pkg::ST_ATTACH;
                end
            hbc_pkg::ST_ATTACH:
                if (!soft_disc_s) begin
                    next_stage = hbc_pkg::ST_NORMAL;
                end
            hbc_pkg::ST_NORMAL:
                if (soft_disc_s) begin
                    next_stage = hbc_pkg::ST_ATTACH;
                end
            default:
                next_stage = hbc_pkg::ST_STANDBY;
        endcase
    end

    // Reset low forces standby at once
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            stage  <= hbc_pkg::ST_STANDBY;
            source <= hbc_pkg::SRC_SELF_PWR;
        end else begin
            stage  <= next_stage;
            source <= next_source;
        end
    end

    // Settle counter, restarted on every stage change
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cnt <= '0;
        end else if (next_stage != stage) begin
            cnt <= '0;
        end else if (!cnt_done) begin
            cnt <= cnt + 1'b1;
        end
    end

    // Straps are caught once the synchroniser holds settled levels
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            strap <= hbc_pkg::SEL_SELF_PWR;
        end else if (stage == hbc_pkg::ST_HARDWARE_INIT_STAGE && cnt_done) begin
            strap <= sel_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // SMBus-written configuration

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            host_done <= 1'b0;
        end else if (stage != hbc_pkg::ST_HOST_CFG) begin
            host_done <= 1'b0;
        end else if (cfg_wr && SMB_WR_ADDR == hbc_pkg::ADDR_CFG_DONE) begin
            host_done <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            host_chg_set <= 1'b0;
            host_chg_val <= hbc_pkg::RST_CHG_EN;
        end else if (cfg_wr && SMB_WR_ADDR == hbc_pkg::ADDR_UPS_CHG) begin
            host_chg_set <= 1'b1;
            host_chg_val <= SMB_WR_DATA[hbc_pkg::BIT_UPS_CHG_EN];
        end
    end

    // Host values override OTP except for EEPROM source, which ORs EEPROM and OTP; OTP overrides defaults
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            UPS_CHG_EN <= hbc_pkg::RST_CHG_EN;
        end else if (stage == hbc_pkg::ST_MERGE &&
                     next_stage == hbc_pkg::ST_APPLY) begin
            if (source == hbc_pkg::SRC_EEPROM) begin
                UPS_CHG_EN <= EEPROM_UPS_CHG_EN | OTP_UPS_CHG_EN;
            end else if (host_chg_set) begin
                UPS_CHG_EN <= host_chg_val;
            end else begin
                UPS_CHG_EN <= OTP_UPS_CHG_EN;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Suspend keep-awake

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            keep_awake <= hbc_pkg::RST_KEEP_AWAKE;
        end else if (cfg_wr && SMB_WR_ADDR == hbc_pkg::ADDR_PORTABLE) begin
            keep_awake <= SMB_WR_DATA[hbc_pkg::BIT_KEEP_AWAKE];
        end
    end

    // Only a setting made before suspend starts counts
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            susp_d        <= 1'b0;
            awake_latched <= 1'b0;
        end else begin
            susp_d <= USB_SUSPEND;
            if (USB_SUSPEND && !susp_d) begin
                awake_latched <= keep_awake;
            end
        end
    end

    assign CLK_STOP_REQ = USB_SUSPEND && !(susp_d && awake_latched);
    assign SMB_ENABLE   = stage != hbc_pkg::ST_STANDBY &&
                          stage != hbc_pkg::ST_HARDWARE_INIT_STAGE &&
                          !CLK_STOP_REQ;

    ////////////////////////////////////////////////////////////////////////
    // Vendor messages

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            VSM_EC_ENABLE     <= hbc_pkg::RST_VSM_EC;
            VSM_RESUME_ENABLE <= hbc_pkg::RST_VSM_RESUME;
            VSM_HUB_RESET     <= 1'b0;
        end else begin
            VSM_HUB_RESET <= VSM_CMD_VALID &&
                             VSM_CMD == hbc_pkg::VSM_HUB_RESET;
            if (VSM_CMD_VALID) begin
                case (VSM_CMD)
                    hbc_pkg::VSM_EC_ON:      VSM_EC_ENABLE     <= 1'b1;
                    hbc_pkg::VSM_EC_OFF:     VSM_EC_ENABLE     <= 1'b0;
                    hbc_pkg::VSM_RESUME_ON:  VSM_RESUME_ENABLE <= 1'b1;
                    hbc_pkg::VSM_RESUME_OFF: VSM_RESUME_ENABLE <= 1'b0;
                    default:                 VSM_EC_ENABLE <= VSM_EC_ENABLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Straps are caught on the same edge that enters firmware init
    logic [1:0] pd_strap;

    assign pd_strap = (stage == hbc_pkg::ST_HARDWARE_INIT_STAGE) ? sel_s : strap;

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            SDA_PD_EN       <= 1'b0;
            SCL_PD_EN       <= 1'b0;
            EEPROM_LOAD_REQ <= 1'b0;
            CFG_APPLY       <= 1'b0;
            CHG_DET_START   <= 1'b0;
            HUB_CONNECT     <= 1'b0;
        end else begin
            SDA_PD_EN       <= next_stage == hbc_pkg::ST_FW_INIT &&
                               pd_strap != hbc_pkg::SEL_EEPROM;
            SCL_PD_EN       <= next_stage == hbc_pkg::ST_FW_INIT &&
                               pd_strap != hbc_pkg::SEL_EEPROM;
            EEPROM_LOAD_REQ <= next_stage == hbc_pkg::ST_MERGE &&
                               next_source == hbc_pkg::SRC_EEPROM;
            CFG_APPLY       <= next_stage == hbc_pkg::ST_APPLY;
            CHG_DET_START   <= next_stage == hbc_pkg::ST_CHG_DET &&
                               stage != hbc_pkg::ST_CHG_DET;
            HUB_CONNECT     <= next_stage == hbc_pkg::ST_NORMAL;
        end
    end

    assign STAGE        = stage;
    assign CFG_SOURCE   = source;
    assign SUSPEND_IDLE = stage == hbc_pkg::ST_IDLE;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking seq_clk @(posedge REF_CLK);
    endclocking

    default disable iff (!RESETN);

    sequence s_host_done;
        stage == hbc_pkg::ST_HOST_CFG && host_done;
    endsequence

    sequence s_merge_entry;
        stage == hbc_pkg::ST_MERGE;
    endsequence

    chk_reset_hwinit: assert property (
        stage == hbc_pkg::ST_STANDBY |=> stage == hbc_pkg::ST_HARDWARE_INIT_STAGE)
        else $error("standby did not lead to hardware init");

    chk_hwinit_quiet: assert property (
        stage == hbc_pkg::ST_HARDWARE_INIT_STAGE |-> !SMB_ENABLE)
        else $error("SMBus served during hardware init");

    chk_clk_needed: assert property (
        stage == hbc_pkg::ST_HARDWARE_INIT_STAGE && !clk_ok_s
        |=> stage == hbc_pkg::ST_HARDWARE_INIT_STAGE)
        else $error("left hardware init without reference clock");

    chk_eeprom_nopd: assert property (
        stage == hbc_pkg::ST_FW_INIT && strap == hbc_pkg::SEL_EEPROM
        |-> !SDA_PD_EN && !SCL_PD_EN)
        else $error("pull-downs enabled with EEPROM straps");

    chk_done_merge: assert property (
        s_host_done |=> s_merge_entry)
        else $error("config-done write did not reach merge");

    chk_host_wait: assert property (
        stage == hbc_pkg::ST_HOST_CFG && !host_done
        |=> stage == hbc_pkg::ST_HOST_CFG)
        else $error("host configuration left without done write");

    chk_idle_hold: assert property (
        stage == hbc_pkg::ST_IDLE && !vbus_s && !attach_s
        |=> stage == hbc_pkg::ST_IDLE)
        else $error("left idle without VBUS or attach");

    chk_chg_route: assert property (
        stage == hbc_pkg::ST_IDLE && vbus_s
        |=> stage == (UPS_CHG_EN ? hbc_pkg::ST_CHG_DET
                                 : hbc_pkg::ST_ATTACH))
        else $error("wrong stage after VBUS");

    chk_chg_start: assert property (
        stage != hbc_pkg::ST_CHG_DET ##1 stage == hbc_pkg::ST_CHG_DET
        |-> CHG_DET_START)
        else $error("charger detection not started");

    chk_soft_disc: assert property (
        stage == hbc_pkg::ST_NORMAL && soft_disc_s
        |=> stage == hbc_pkg::ST_ATTACH && !HUB_CONNECT)
        else $error("soft disconnect did not return to attach");

    chk_susp_quiet: assert property (
        USB_SUSPEND && !awake_latched |-> !SMB_ENABLE)
        else $error("SMBus served in suspend without keep-awake");

    chk_keep_awake: assert property (
        $rose(USB_SUSPEND) && keep_awake && stage == hbc_pkg::ST_NORMAL
        ##1 USB_SUSPEND |-> SMB_ENABLE)
        else $error("keep-awake did not keep SMBus alive");

endmodule // hbc_boot_seq

// File: sim/hbc_far_model.sv
// Far-side model: SMBus host, configuration EEPROM and charger detector
`timescale 1ns/1ps
module hbc_far_model #(
    parameter int DLY = 5
) (
    input  wire logic       clk,
    input  wire logic       load_req,
    input  wire logic       det_start,
    output logic            wr_valid,
    output logic [7:0]      wr_addr,
    output logic [7:0]      wr_data,
    output logic            load_done,
    output logic            det_done
);
    int ee_cnt = 0;
    int det_cnt = 0;

    initial begin
        wr_valid = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
        load_done = 1'b0;
        det_done = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One byte write; released lines flip so stale values never match
    task automatic smb_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_valid = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge clk);
        wr_valid = 1'b0;
        wr_addr = ~a;
        wr_data = ~d;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Slow answers on purpose: done only after DLY cycles
    always @(negedge clk) begin
        ee_cnt = load_req ? ee_cnt + 1 : 0;
        load_done <= (ee_cnt >= DLY);
        det_cnt = det_start ? 1 : (det_cnt > 0 ? det_cnt + 1 : 0);
        det_done <= (det_cnt == DLY);
        if (det_cnt >= DLY) det_cnt = 0;
    end
endmodule // hbc_far_model

// File: sim/hbc_boot_seq_bench.sv
// Self-checking bench of the hub boot and configuration sequencer
`timescale 1ns/1ps
module hbc_boot_seq_bench;
    logic       ref_clk = 0, resetn = 0, clk_ok = 0, sda = 0, vbus = 0;
    logic       soft_dis = 0, susp = 0, otp_chg = 0, vsm_v = 0, attach = 0;
    logic [1:0] strap = 2'h0;
    logic [2:0] vendor_message_commands = 3'h0;
    logic       wr_v, ee_done, det_done, sda_pd, scl_pd, smb_en, clk_stop;
    logic       ee_req, apply, chg_en, det_go, conn, idle;
    logic       vsm_ec, vsm_res, vsm_rst;
    logic [7:0] wr_a, wr_d;
    logic [3:0] stage;
    logic [2:0] src;
    int         fail_count = 0;
    int         checks = 0;

    always #5 ref_clk = ~ref_clk;

    hbc_boot_seq i_hbc_boot_seq (
        .REF_CLK(ref_clk), .RESETN(resetn), .REF_CLK_OK(clk_ok),
        .STRAP_CFG_SEL(strap), .SDA_IN(sda), .SCL_IN(sda),
        .VBUS_PRESENT(vbus), .HUB_ATTACH_REQ(attach),
        .SOFT_DISCONNECT(soft_dis), .USB_SUSPEND(susp),
        .OTP_UPS_CHG_EN(otp_chg), .SMB_WR_VALID(wr_v), .SMB_WR_ADDR(wr_a),
        .SMB_WR_DATA(wr_d), .EEPROM_LOAD_DONE(ee_done),
        .EEPROM_UPS_CHG_EN(1'b0), .CHG_DET_DONE(det_done),
        .VSM_CMD_VALID(vsm_v), .VSM_CMD(vendor_message_commands), .SDA_PD_EN(sda_pd),
        .SCL_PD_EN(scl_pd), .SMB_ENABLE(smb_en), .CLK_STOP_REQ(clk_stop),
        .STAGE(stage), .CFG_SOURCE(src), .EEPROM_LOAD_REQ(ee_req),
        .CFG_APPLY(apply), .UPS_CHG_EN(chg_en), .CHG_DET_START(det_go),
        .HUB_CONNECT(conn), .SUSPEND_IDLE(idle), .VSM_EC_ENABLE(vsm_ec),
        .VSM_RESUME_ENABLE(vsm_res), .VSM_HUB_RESET(vsm_rst));

    hbc_far_model i_hbc_far_model (
        .clk(ref_clk), .load_req(ee_req), .det_start(det_go),
        .wr_valid(wr_v), .wr_addr(wr_a), .wr_data(wr_d),
        .load_done(ee_done), .det_done(det_done));

    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bounded wait; covers the 200-cycle pull-down settle
    task automatic wait_st(input logic [3:0] st);
        int n = 0;
        while (stage !== st && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        cmp(stage, st);
    endtask

    // Pull-ups on both lines modelled by pu; they beat the weak pull-downs
    task automatic boot(input logic [1:0] s, input logic pu, input logic ok);
        @(negedge ref_clk);
        resetn = 0;
        vbus = 0;
        attach = 0;
        susp = 0;
        strap = s;
        sda = pu;
        clk_ok = ok;
        repeat (6) @(negedge ref_clk);
        cmp(stage, hbc_pkg::ST_STANDBY);
        resetn = 1;
        @(negedge ref_clk);
        cmp(stage, hbc_pkg::ST_HARDWARE_INIT_STAGE);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_clock;
        boot(2'h0, 1'b0, 1'b0);
        repeat (50) @(negedge ref_clk);
        cmp(stage, hbc_pkg::ST_HARDWARE_INIT_STAGE);
        cmp(smb_en, 1'b0);
        clk_ok = 1;
        wait_st(hbc_pkg::ST_FW_INIT);
        cmp({sda_pd, scl_pd}, 2'h3);
        wait_st(hbc_pkg::ST_IDLE);
        cmp(src, hbc_pkg::SRC_SELF_PWR);
        cmp(idle, 1'b1);
        $display("t_clock done");
    endtask

    task automatic t_bus;
        boot(2'h2, 1'b0, 1'b1);
        wait_st(hbc_pkg::ST_APPLY);
        cmp(apply, 1'b1);
        wait_st(hbc_pkg::ST_IDLE);
        cmp(apply, 1'b0);
        cmp(src, hbc_pkg::SRC_BUS_PWR);
        attach = 1;
        wait_st(hbc_pkg::ST_NORMAL);
        $display("t_bus done");
    endtask

    task automatic t_eeprom;
        boot(2'h3, 1'b1, 1'b1);
        wait_st(hbc_pkg::ST_MERGE);
        cmp(ee_req, 1'b1);
        cmp({sda_pd, scl_pd}, 2'h0);
        cmp(src, hbc_pkg::SRC_EEPROM);
        wait_st(hbc_pkg::ST_IDLE);
        $display("t_eeprom done");
    endtask

    task automatic t_invalid;
        boot(2'h1, 1'b0, 1'b1);
        repeat (300) @(negedge ref_clk);
        cmp(stage, hbc_pkg::ST_FW_INIT);
        cmp(src, hbc_pkg::SRC_INVALID);
        $display("t_invalid done");
    endtask

    task automatic t_host;
        boot(2'h1, 1'b1, 1'b1);
        wait_st(hbc_pkg::ST_HOST_CFG);
        cmp(src, hbc_pkg::SRC_HOST);
        repeat (500) @(negedge ref_clk);
        cmp(stage, hbc_pkg::ST_HOST_CFG);
        i_hbc_far_model.smb_write(hbc_pkg::ADDR_UPS_CHG, 8'h01);
        i_hbc_far_model.smb_write(hbc_pkg::ADDR_PORTABLE, 8'h01);
        i_hbc_far_model.smb_write(hbc_pkg::ADDR_CFG_DONE, 8'h00);
        wait_st(hbc_pkg::ST_IDLE);
        cmp(chg_en, 1'b1);
        vbus = 1;
        wait_st(hbc_pkg::ST_CHG_DET);
        cmp(det_go, 1'b1);
        wait_st(hbc_pkg::ST_NORMAL);
        cmp(conn, 1'b1);
        soft_dis = 1;
        wait_st(hbc_pkg::ST_ATTACH);
        repeat (20) @(negedge ref_clk);
        cmp({stage, conn}, {hbc_pkg::ST_ATTACH, 1'b0});
        soft_dis = 0;
        wait_st(hbc_pkg::ST_NORMAL);
        susp = 1;
        @(negedge ref_clk);
        cmp({smb_en, clk_stop}, 2'h2);
        $display("t_host done");
    endtask

    // Straps 00 with pulled-up lines still lead to host configuration
    task automatic t_direct;
        boot(2'h0, 1'b1, 1'b1);
        wait_st(hbc_pkg::ST_HOST_CFG);
        i_hbc_far_model.smb_write(hbc_pkg::ADDR_CFG_DONE, 8'h00);
        wait_st(hbc_pkg::ST_IDLE);
        vbus = 1;
        wait_st(hbc_pkg::ST_NORMAL);
        susp = 1;
        @(negedge ref_clk);
        cmp({smb_en, clk_stop}, 2'h1);
        $display("t_direct done");
    endtask

    task automatic t_vsm;
        logic ec = 0;
        logic rs = 0;
        boot(2'h0, 1'b0, 1'b1);
        // Valid held high across the run of commands
        vsm_v = 1;
        for (int c = 1; c < 7; c++) begin
            vendor_message_commands = 3'(c);
            @(negedge ref_clk);
            if (c == 1 || c == 2) ec = (c == 1);
            if (c == 3 || c == 4) rs = (c == 3);
            cmp({vsm_ec, vsm_res, vsm_rst}, {ec, rs, c == 5});
        end
        vsm_v = 0;
        $display("t_vsm done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Tests need about 1850 cycles; allow ample margin
    initial begin
        #200000;
        fail_count++;
        $display("Watchdog expired at %0t", $time);
        give_verdict();
    end

    initial begin
        repeat (6) @(negedge ref_clk);
        resetn = 1;
        t_clock();
        t_bus();
        t_eeprom();
        t_invalid();
        t_host();
        t_direct();
        t_vsm();
        give_verdict();
    end
endmodule // hbc_boot_seq_bench
